// ---- rtl/atc_top.sv ----
// Timer channel slice: registers, prescaler, counter, capture and outputs
//
// What this block does
// - Two-bit field at ch3 control [1:0] selects channel direction.
// - Output direction: clear-enable b7, mode [6:4], preload b3, fast b2.
// - Input direction: filter [7:4], capture divider [3:2]; [15:8] zero.
// - Enable register: enable, polarity, comp enable, comp polarity each.
// - Output polarity 1 makes compare output active low.
// - Input polarity 1 inverts input, capturing on falling edges.
// - Polarity bit writes ignored at lock level 2 or 3.
// - Complementary polarity and enable sit at group bits 3 and 2.
// - Output enable bit routes compare signal to the pin.
// - Input enable bit gates capture of the counter value.
// - Live 16-bit counter readable and writable, software loads it.
// - Counting clock is timer clock divided by divider plus one.
// - Direction codes: output, own pin, paired pin (ch3 pairs with its own pin), internal trigger.
// - Direction field writable only while channel enable is zero.
// - Brake clears main output enable at once; outputs idle then.
`timescale 1ns/10ps
`default_nettype none
module atc_top (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire atc_pkg::atc_bus_t bus_in,
    output logic [15:0] rdata_out,
    input wire logic [2:0] chan_pin_in,
    input wire logic trigger_in,
    input wire logic brake_in,
    output atc_pkg::atc_pins_t pins_out
);
    logic [15:0] ch3_mode_r;
    logic [15:0] enable_r;
    logic [15:0] count_r;
    logic [15:0] divider_r;
    logic [15:0] div_cnt_r;
    logic [15:0] brake_r;
    logic [15:0] cap_r [0:2];
    logic [15:0] rdata_r;
    logic [2:0] pin_s1_r;
    logic [2:0] pin_s2_r;
    logic [2:0] pin_d_r;
    logic trig_s1_r;
    logic trig_s2_r;
    logic trig_d_r;
    logic brake_s1_r;
    logic brake_s2_r;
    atc_pkg::atc_pins_t pins_r;
    atc_pkg::atc_pins_t pins_nxt;

    // Write decode
    logic wr_mode;
    logic wr_en;
    logic wr_cnt;
    logic wr_div;
    logic wr_brk;
    assign wr_mode = bus_in.wr && bus_in.addr == atc_pkg::OFF_CH3_MODE;
    assign wr_en = bus_in.wr && bus_in.addr == atc_pkg::OFF_ENABLE;
    assign wr_cnt = bus_in.wr && bus_in.addr == atc_pkg::OFF_COUNT;
    assign wr_div = bus_in.wr && bus_in.addr == atc_pkg::OFF_DIVIDER;
    assign wr_brk = bus_in.wr && bus_in.addr == atc_pkg::OFF_BRAKE_CTL;

    // Lock level and direction fields
    logic [1:0] lock_lvl;
    logic pol_locked;
    logic [1:0] ch3_dir;
    logic ch3_is_out;
    assign lock_lvl = brake_r[atc_pkg::BK_LOCK_LO +: 2];
    assign pol_locked = lock_lvl == atc_pkg::LOCK_L2 ||
                        lock_lvl == atc_pkg::LOCK_L3;
    assign ch3_dir = ch3_mode_r[1:0];
    assign ch3_is_out = ch3_dir == atc_pkg::DIR_OUT;

    // Channel 3 mode next value; direction held while channel enabled
    logic [15:0] mode_wval;
    assign mode_wval = {8'h00, bus_in.wdata[7:2],
        enable_r[2*atc_pkg::EN_GRP_W + atc_pkg::EN_BIT_ENABLE] ?
        ch3_mode_r[1:0] : bus_in.wdata[1:0]};

    // Enable register next value; polarity bits frozen under lock
    logic [15:0] pol_mask;
    logic [15:0] en_wval;
    assign pol_mask = 16'h0AAA; // polarity and comp polarity bits
    assign en_wval = pol_locked ?
        ((bus_in.wdata & ~pol_mask) | (enable_r & pol_mask)) :
        bus_in.wdata;

    // Register stores
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            ch3_mode_r <= atc_pkg::RST_CH3_MODE;
            enable_r <= atc_pkg::RST_ENABLE;
            divider_r <= atc_pkg::RST_DIVIDER;
        end else begin
            if (wr_mode) begin
                ch3_mode_r <= mode_wval & atc_pkg::MASK_CH3_MODE;
            end
            if (wr_en) begin
                enable_r <= en_wval & atc_pkg::MASK_ENABLE;
            end
            if (wr_div) begin
                divider_r <= bus_in.wdata;
            end
        end
    end

    // Main output enable: brake clears it, brake wins over a write
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            brake_r <= 16'h0000;
        end else if (brake_s2_r) begin
            brake_r[atc_pkg::BK_BIT_MOE] <= 1'b0;
            if (wr_brk) begin
                brake_r[14:0] <= bus_in.wdata[14:0] &
                                 atc_pkg::MASK_BRAKE[14:0];
            end
        end else if (wr_brk) begin
            brake_r <= bus_in.wdata & atc_pkg::MASK_BRAKE;
        end
    end

    // Pin, trigger and brake synchronisers
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            pin_s1_r <= 3'h0;
            pin_s2_r <= 3'h0;
            pin_d_r <= 3'h0;
            trig_s1_r <= 1'b0;
            trig_s2_r <= 1'b0;
            trig_d_r <= 1'b0;
            brake_s1_r <= 1'b0;
            brake_s2_r <= 1'b0;
        end else begin
            pin_s1_r <= chan_pin_in;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
            trig_s1_r <= trigger_in;
            trig_s2_r <= trig_s1_r;
            trig_d_r <= trig_s2_r;
            brake_s1_r <= brake_in;
            brake_s2_r <= brake_s1_r;
        end
    end

    // Prescaler tick every divider+1 clocks; >= ends a shortened period
    logic tick;
    assign tick = div_cnt_r >= divider_r;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            div_cnt_r <= 16'h0000;
        end else if (tick) begin
            div_cnt_r <= 16'h0000;
        end else begin
            div_cnt_r <= div_cnt_r + 16'h0001;
        end
    end

    // Counter: a software write loads it, else it advances per tick
    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            count_r <= atc_pkg::RST_COUNT;
        end else if (wr_cnt) begin
            count_r <= bus_in.wdata;
        end else if (tick) begin
            count_r <= count_r + 16'h0001;
        end
    end

    // Capture source selection and edge detection per channel
    logic [2:0] chan_out_dir;
    logic [2:0] src_now;
    logic [2:0] src_old;
    logic [2:0] cap_evt;
    logic [1:0] ch_dir [0:2];
    assign ch_dir[0] = atc_pkg::DIR_OWN;
    assign ch_dir[1] = atc_pkg::DIR_OWN;
    assign ch_dir[2] = ch3_dir;

    genvar gi;
    generate
        for (gi = 0; gi < atc_pkg::NUM_CH; gi++) begin : g_cap
            localparam int PAIR = (gi == 0) ? 1 : (gi == 1) ? 0 : 2;
            logic pol;
            logic en;
            assign pol = enable_r[gi*atc_pkg::EN_GRP_W + atc_pkg::EN_BIT_POL];
            assign en = enable_r[gi*atc_pkg::EN_GRP_W +
                                 atc_pkg::EN_BIT_ENABLE];
            assign chan_out_dir[gi] = ch_dir[gi] == atc_pkg::DIR_OUT;
            // Source per direction code, then optional inversion
            assign src_now[gi] = pol ^ (
                ch_dir[gi] == atc_pkg::DIR_PAIR ? pin_s2_r[PAIR] :
                ch_dir[gi] == atc_pkg::DIR_TRIG ? trig_s2_r :
                pin_s2_r[gi]);
            assign src_old[gi] = pol ^ (
                ch_dir[gi] == atc_pkg::DIR_PAIR ? pin_d_r[PAIR] :
                ch_dir[gi] == atc_pkg::DIR_TRIG ? trig_d_r :
                pin_d_r[gi]);
            assign cap_evt[gi] = !chan_out_dir[gi] && en &&
                                 src_now[gi] && !src_old[gi];
            always_ff @(posedge clk_in) begin
                if (!reset_n_in) begin
                    cap_r[gi] <= 16'h0000;
                end else if (cap_evt[gi]) begin
                    cap_r[gi] <= count_r;
                end
            end
        end
    endgenerate

    // Compare reference for channel 3 from the mode field
    logic [2:0] ch3_mode;
    logic ch3_ref;
    logic [2:0] ref_lvl;
    logic cmp_hit;
    assign ch3_mode = ch3_mode_r[6:4];
    assign cmp_hit = count_r < cap_r[2];
    assign ch3_ref = ch3_mode == atc_pkg::MODE_PWM1 ? cmp_hit :
                     ch3_mode == atc_pkg::MODE_PWM2 ? !cmp_hit : 1'b0;
    assign ref_lvl = {ch3_is_out ? ch3_ref : 1'b0, 2'b00};

    // Output stage per channel
    generate
        for (gi = 0; gi < atc_pkg::NUM_CH; gi++) begin : g_out
            localparam int B = gi * atc_pkg::EN_GRP_W;
            atc_chan_out u_out (
                .ref_in(ref_lvl[gi]),
                .enable_in(enable_r[B + atc_pkg::EN_BIT_ENABLE] &&
                           chan_out_dir[gi]),
                .polarity_in(enable_r[B + atc_pkg::EN_BIT_POL]),
                .comp_enable_in(enable_r[B + atc_pkg::EN_BIT_CENABLE]),
                .comp_polarity_in(enable_r[B + atc_pkg::EN_BIT_CPOL]),
                .moe_in(brake_r[atc_pkg::BK_BIT_MOE] && !brake_s2_r),
                .run_off_state_sel_in(brake_r[atc_pkg::BK_BIT_RUN_OFF_STATE_SEL]),
                .idle_off_state_sel_in(brake_r[atc_pkg::BK_BIT_IDLE_OFF_STATE_SEL]),
                .idle_in(brake_r[atc_pkg::BK_IDLE_LO + 2*gi]),
                .idle_n_in(brake_r[atc_pkg::BK_IDLE_LO + 2*gi + 1]),
                .pin_out(pins_nxt.pin[gi]),
                .pin_n_out(pins_nxt.pin_n[gi]),
                .oe_out(pins_nxt.pin_oe[gi]),
                .oe_n_out(pins_nxt.pin_n_oe[gi])
            );
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    logic [15:0] rdata_nxt;
    assign rdata_nxt =
        bus_in.addr == atc_pkg::OFF_CH3_MODE ? ch3_mode_r :
        bus_in.addr == atc_pkg::OFF_ENABLE ? enable_r :
        bus_in.addr == atc_pkg::OFF_COUNT ? count_r :
        bus_in.addr == atc_pkg::OFF_DIVIDER ? divider_r :
        bus_in.addr == atc_pkg::OFF_BRAKE_CTL ? brake_r :
        bus_in.addr == atc_pkg::OFF_CAPTURE1 ? cap_r[0] :
        bus_in.addr == atc_pkg::OFF_CAPTURE2 ? cap_r[1] :
        bus_in.addr == atc_pkg::OFF_CAPTURE3 ? cap_r[2] : 16'h0000;

    always_ff @(posedge clk_in) begin
        if (!reset_n_in) begin
            rdata_r <= 16'h0000;
            pins_r <= '0;
        end else begin
            rdata_r <= bus_in.rd ? rdata_nxt : 16'h0000;
            pins_r <= pins_nxt;
        end
    end

    assign rdata_out = rdata_r;
    assign pins_out = pins_r;

    // Checks
    property p_dir_hold;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wr_mode && enable_r[8]) |=> $stable(ch3_mode_r[1:0]);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("dir changed");

    property p_pol_lock;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wr_en && pol_locked) |=> ((enable_r & pol_mask) ==
                                   ($past(enable_r) & pol_mask));
    endproperty
    a_pol_lock: assert property (p_pol_lock)
        else $error("pol written");

    property p_cnt_load;
        @(posedge clk_in) disable iff (!reset_n_in)
        wr_cnt |=> count_r == $past(bus_in.wdata);
    endproperty
    a_cnt_load: assert property (p_cnt_load) else $error("no load");

    property p_tick_gap;
        @(posedge clk_in) disable iff (!reset_n_in)
        (tick && divider_r == 16'h0003 && !wr_div) |=> !tick [*3] ##1 tick;
    endproperty
    a_tick_gap: assert property (p_tick_gap) else $error("bad div");

    property p_mode_hi;
        @(posedge clk_in) disable iff (!reset_n_in)
        bus_in.wr |=> ch3_mode_r[15:8] == 8'h00;
    endproperty
    a_mode_hi: assert property (p_mode_hi) else $error("mode hi set");

    property p_cap_gate;
        @(posedge clk_in) disable iff (!reset_n_in)
        !enable_r[8] |=> $stable(cap_r[2]);
    endproperty
    a_cap_gate: assert property (p_cap_gate) else $error("capture");

    property p_brake;
        @(posedge clk_in) disable iff (!reset_n_in)
        brake_s2_r |=> !brake_r[atc_pkg::BK_BIT_MOE] ##1
                       pins_out.pin[2] == brake_r[4];
    endproperty
    a_brake: assert property (p_brake) else $error("brake idle");

    property p_out_pol;
        @(posedge clk_in) disable iff (!reset_n_in)
        (brake_r[15] && !brake_s2_r && enable_r[8] && ch3_is_out) |=>
            pins_out.pin[2] == ($past(ch3_ref) ^ $past(enable_r[9]));
    endproperty
    a_out_pol: assert property (p_out_pol) else $error("polarity");

    property p_cap_take;
        @(posedge clk_in) disable iff (!reset_n_in)
        cap_evt[2] |=> cap_r[2] == $past(count_r);
    endproperty
    a_cap_take: assert property (p_cap_take)
        else $error("capture lost");

    property p_cap_gate1;
        @(posedge clk_in) disable iff (!reset_n_in)
        !enable_r[atc_pkg::EN_BIT_ENABLE] |=> $stable(cap_r[0]);
    endproperty
    a_cap_gate1: assert property (p_cap_gate1)
        else $error("ch1 captured while off");

    property p_mode_write;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wr_mode && !enable_r[8]) |=>
            ch3_mode_r == ($past(bus_in.wdata) & atc_pkg::MASK_CH3_MODE);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode write lost");

    property p_en_write;
        @(posedge clk_in) disable iff (!reset_n_in)
        (wr_en && !pol_locked) |=>
            enable_r == ($past(bus_in.wdata) & atc_pkg::MASK_ENABLE);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("enable write lost");

    property p_off_pin;
        @(posedge clk_in) disable iff (!reset_n_in)
        (brake_r[atc_pkg::BK_BIT_MOE] && !brake_s2_r && !enable_r[8] &&
         ch3_is_out) |=> pins_out.pin[2] == $past(enable_r[9]);
    endproperty
    a_off_pin: assert property (p_off_pin)
        else $error("disabled pin not inactive");
endmodule
`default_nettype wire

// ---- rtl/atc_pkg.sv ----
// Package: register map, field positions and types of the timer channel slice
package atc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CH3_MODE = 8'h1C;
    localparam logic [7:0] OFF_COUNT = 8'h24;
    localparam logic [7:0] OFF_ENABLE = 8'h20;
    localparam logic [7:0] OFF_DIVIDER = 8'h28;
    localparam logic [7:0] OFF_BRAKE_CTL = 8'h44;
    localparam logic [7:0] OFF_CAPTURE1 = 8'h34;
    localparam logic [7:0] OFF_CAPTURE2 = 8'h38;
    localparam logic [7:0] OFF_CAPTURE3 = 8'h3C;
    localparam logic [15:0] RST_CH3_MODE = 16'h0000;
    localparam logic [15:0] RST_COUNT = 16'h0000;
    localparam logic [15:0] RST_ENABLE = 16'h0000;
    localparam logic [15:0] RST_DIVIDER = 16'h0000;
    localparam logic [15:0] MASK_CH3_MODE = 16'h00FF;
    localparam logic [15:0] MASK_ENABLE = 16'h0FFF;
    // Enable register: four bits per channel
    localparam int EN_GRP_W = 4;
    localparam int EN_BIT_ENABLE = 0;
    localparam int EN_BIT_POL = 1;
    localparam int EN_BIT_CENABLE = 2;
    localparam int EN_BIT_CPOL = 3;
    localparam int NUM_CH = 3;
    // Brake control register fields
    localparam int BK_BIT_MOE = 15;
    localparam int BK_BIT_RUN_OFF_STATE_SEL = 11;
    localparam int BK_BIT_IDLE_OFF_STATE_SEL = 10;
    localparam int BK_LOCK_LO = 8;
    localparam int BK_IDLE_LO = 0;
    localparam logic [15:0] MASK_BRAKE = 16'h8F3F;
    localparam logic [1:0] LOCK_L2 = 2'h2;
    localparam logic [1:0] LOCK_L3 = 2'h3;
    // Channel direction select encodings
    localparam logic [1:0] DIR_OUT = 2'h0;
    localparam logic [1:0] DIR_OWN = 2'h1;
    localparam logic [1:0] DIR_PAIR = 2'h2;
    localparam logic [1:0] DIR_TRIG = 2'h3;
    localparam logic [2:0] MODE_INACTIVE = 3'h0;
    localparam logic [2:0] MODE_PWM1 = 3'h6;
    localparam logic [2:0] MODE_PWM2 = 3'h7;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } atc_bus_t;

    typedef struct packed {
        logic [2:0] pin;
        logic [2:0] pin_n;
        logic [2:0] pin_oe;
        logic [2:0] pin_n_oe;
    } atc_pins_t;
endpackage

// ---- rtl/atc_chan_out.sv ----
// One channel's output stage: polarity, enable, idle and off-state steering
`timescale 1ns/10ps
`default_nettype none
module atc_chan_out (
    input wire logic ref_in,
    input wire logic enable_in,
    input wire logic polarity_in,
    input wire logic comp_enable_in,
    input wire logic comp_polarity_in,
    input wire logic moe_in,
    input wire logic run_off_state_sel_in,
    input wire logic idle_off_state_sel_in,
    input wire logic idle_in,
    input wire logic idle_n_in,
    output logic pin_out,
    output logic pin_n_out,
    output logic oe_out,
    output logic oe_n_out
);
    logic main_lvl;
    logic comp_lvl;
    // Polarity 1 makes the active level low
    assign main_lvl = ref_in ^ polarity_in;
    assign comp_lvl = ~ref_in ^ comp_polarity_in;
    // Routing to pins; main enable low forces idle levels
    assign pin_out = !moe_in ? idle_in :
                     enable_in ? main_lvl : polarity_in;
    assign pin_n_out = !moe_in ? idle_n_in :
                       comp_enable_in ? comp_lvl : comp_polarity_in;
    assign oe_out = moe_in ? (enable_in | run_off_state_sel_in) : idle_off_state_sel_in;
    assign oe_n_out = moe_in ? (comp_enable_in | run_off_state_sel_in) : idle_off_state_sel_in;
endmodule
`default_nettype wire

// ---- dv/atc_pin_model.sv ----
// Far-side model: drives channel pins, internal trigger and brake lines
`timescale 1ns/10ps
`default_nettype none
module atc_pin_model (
    input wire logic clk_in,
    output logic [2:0] pin_out,
    output logic trig_out,
    output logic brake_out
);
    // Lines start low; every change lands just after a rising edge
    initial begin
        pin_out = 3'h0;
        trig_out = 1'b0;
        brake_out = 1'b0;
    end

    // Set one line; index 3 selects the internal trigger line
    task automatic drive(input int idx, input logic lvl);
        @(posedge clk_in);
        if (idx == 3) begin
            trig_out <= lvl;
        end else begin
            pin_out[idx] <= lvl;
        end
    endtask

    // Raise or drop the brake level
    task automatic brake(input logic lvl);
        @(posedge clk_in);
        brake_out <= lvl;
    endtask
endmodule
`default_nettype wire

// ---- dv/atc_top_tb_top.sv ----
// Self-checking bench for the timer channel slice
`timescale 1ns/10ps
`default_nettype none
module atc_top_tb_top;
    logic clk_in;
    logic reset_n_in;
    atc_pkg::atc_bus_t bus_r;
    logic [15:0] rdata_out;
    logic [2:0] pin_w;
    logic trig_w;
    logic brake_w;
    atc_pkg::atc_pins_t pins_out;
    int fails;
    int cmp_count;

    atc_top dut_u (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .bus_in(bus_r),
        .rdata_out(rdata_out),
        .chan_pin_in(pin_w),
        .trigger_in(trig_w),
        .brake_in(brake_w),
        .pins_out(pins_out)
    );

    atc_pin_model pm_u (
        .clk_in(clk_in),
        .pin_out(pin_w),
        .trig_out(trig_w),
        .brake_out(brake_w)
    );

    // 200 MHz clock
    initial clk_in = 1'b0;
    always #2.5 clk_in = ~clk_in;

    // Compare one word and count it
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_in);
        bus_r.wr <= 1'b1;
        bus_r.addr <= a;
        bus_r.wdata <= d;
        @(posedge clk_in);
        bus_r.wr <= 1'b0;
    endtask

    // One-cycle read strobe; data stands only in the following cycle
    task automatic rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk_in);
        bus_r.rd <= 1'b1;
        bus_r.addr <= a;
        @(posedge clk_in);
        bus_r.rd <= 1'b0;
        #1 v = rdata_out;
    endtask

    // Read and compare in one step
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        chk(v, exp);
    endtask

    // Drive a line, then see whether the capture register took the counter
    task automatic cap(input int idx, input logic lvl, input logic [7:0] a,
                       input logic exp);
        logic [15:0] old;
        logic [15:0] c;
        logic [15:0] v;
        rd(a, old);
        pm_u.drive(idx, lvl);
        repeat (8) @(posedge clk_in);
        rd(atc_pkg::OFF_COUNT, c);
        rd(a, v);
        if (exp) begin
            chk({15'h0000, (c - v) < 16'h0008}, 16'h0001);
            chk({15'h0000, v != old}, 16'h0001);
        end else begin
            chk(v, old);
        end
    endtask

    // Reset values and an unmapped read
    task automatic t_reset();
        logic [15:0] v;
        rchk(atc_pkg::OFF_CH3_MODE, 16'h0000);
        rchk(atc_pkg::OFF_ENABLE, 16'h0000);
        rchk(atc_pkg::OFF_DIVIDER, 16'h0000);
        rchk(atc_pkg::OFF_BRAKE_CTL, 16'h0000);
        rchk(8'h10, 16'h0000);
        rd(atc_pkg::OFF_COUNT, v);
        chk({15'h0000, v != 16'h0000}, 16'h0001);
        @(posedge clk_in);
        #1 chk(rdata_out, 16'h0000);
        $display("test reset done");
    endtask

    // Field widths, reserved bits and the guarded direction field
    task automatic t_fields();
        wr(atc_pkg::OFF_CH3_MODE, 16'hFFFF);
        rchk(atc_pkg::OFF_CH3_MODE, 16'h00FF);
        wr(atc_pkg::OFF_ENABLE, 16'hFFFF);
        rchk(atc_pkg::OFF_ENABLE, 16'h0FFF);
        wr(atc_pkg::OFF_CH3_MODE, 16'h0000);
        rchk(atc_pkg::OFF_CH3_MODE, 16'h0003);
        wr(atc_pkg::OFF_ENABLE, 16'h0000);
        wr(atc_pkg::OFF_CH3_MODE, 16'h0000);
        rchk(atc_pkg::OFF_CH3_MODE, 16'h0000);
        $display("test fields done");
    endtask

    // Counter load and divide-by-four counting rate
    task automatic t_count();
        logic [15:0] a;
        logic [15:0] b;
        wr(atc_pkg::OFF_DIVIDER, 16'h0003);
        rchk(atc_pkg::OFF_DIVIDER, 16'h0003);
        wr(atc_pkg::OFF_COUNT, 16'h1234);
        rd(atc_pkg::OFF_COUNT, a);
        chk({15'h0000, (a - 16'h1234) < 16'h0002}, 16'h0001);
        rd(atc_pkg::OFF_COUNT, a);
        repeat (38) @(posedge clk_in);
        rd(atc_pkg::OFF_COUNT, b);
        chk(b - a, 16'h000A);
        $display("test count done");
    endtask

    // Capture gating, edge polarity and the channel 3 sources
    task automatic t_capture();
        wr(atc_pkg::OFF_ENABLE, 16'h0001);
        cap(0, 1'b1, atc_pkg::OFF_CAPTURE1, 1'b1);
        wr(atc_pkg::OFF_ENABLE, 16'h0000);
        pm_u.drive(0, 1'b0);
        cap(0, 1'b1, atc_pkg::OFF_CAPTURE1, 1'b0);
        wr(atc_pkg::OFF_ENABLE, 16'h0030);
        cap(1, 1'b1, atc_pkg::OFF_CAPTURE2, 1'b0);
        cap(1, 1'b0, atc_pkg::OFF_CAPTURE2, 1'b1);
        for (int d = 1; d <= 3; d++) begin
            wr(atc_pkg::OFF_ENABLE, 16'h0000);
            pm_u.drive(2, 1'b0);
            pm_u.drive(3, 1'b0);
            wr(atc_pkg::OFF_CH3_MODE, 16'(d));
            wr(atc_pkg::OFF_ENABLE, 16'h0100);
            if (d == 3) begin
                cap(2, 1'b1, atc_pkg::OFF_CAPTURE3, 1'b0);
            end
            cap(d == 3 ? 3 : 2, 1'b1, atc_pkg::OFF_CAPTURE3, 1'b1);
        end
        $display("test capture done");
    endtask

    // Output polarity, enable routing and brake
    task automatic t_output();
        logic [15:0] v;
        wr(atc_pkg::OFF_ENABLE, 16'h0000);
        wr(atc_pkg::OFF_CH3_MODE, 16'h0070);
        wr(atc_pkg::OFF_BRAKE_CTL, 16'h8000);
        wr(atc_pkg::OFF_ENABLE, 16'h0100);
        repeat (4) @(posedge clk_in);
        chk({12'h0, pins_out.pin[2], pins_out.pin_oe[2],
             pins_out.pin_n[2], pins_out.pin_n_oe[2]}, 16'h000C);
        wr(atc_pkg::OFF_ENABLE, 16'h0300);
        repeat (4) @(posedge clk_in);
        chk({14'h0, pins_out.pin[2], pins_out.pin_oe[2]}, 16'h0001);
        wr(atc_pkg::OFF_ENABLE, 16'h0D00);
        repeat (4) @(posedge clk_in);
        chk({14'h0, pins_out.pin_n[2], pins_out.pin_n_oe[2]},
            16'h0003);
        wr(atc_pkg::OFF_ENABLE, 16'h0000);
        repeat (4) @(posedge clk_in);
        chk({15'h0, pins_out.pin_oe[2]}, 16'h0000);
        wr(atc_pkg::OFF_ENABLE, 16'h0100);
        pm_u.brake(1'b1);
        repeat (6) @(posedge clk_in);
        chk({14'h0, pins_out.pin[2], pins_out.pin_oe[2]}, 16'h0000);
        rd(atc_pkg::OFF_BRAKE_CTL, v);
        chk({15'h0, v[15]}, 16'h0000);
        pm_u.brake(1'b0);
        $display("test output done");
    endtask

    // Polarity writes refused under lock levels 2 and 3
    task automatic t_lock();
        wr(atc_pkg::OFF_ENABLE, 16'h0000);
        wr(atc_pkg::OFF_BRAKE_CTL, 16'h0200);
        wr(atc_pkg::OFF_ENABLE, 16'h0FFF);
        rchk(atc_pkg::OFF_ENABLE, 16'h0555);
        wr(atc_pkg::OFF_BRAKE_CTL, 16'h0000);
        wr(atc_pkg::OFF_ENABLE, 16'h0AAA);
        wr(atc_pkg::OFF_BRAKE_CTL, 16'h0300);
        wr(atc_pkg::OFF_ENABLE, 16'h0000);
        rchk(atc_pkg::OFF_ENABLE, 16'h0AAA);
        $display("test lock done");
    endtask

    // Print counts and verdict, then stop
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        fails = 0;
        cmp_count = 0;
        bus_r = '0;
        reset_n_in = 1'b0;
        repeat (3) @(posedge clk_in);
        reset_n_in <= 1'b1;
        t_reset();
        t_fields();
        t_count();
        t_capture();
        t_output();
        t_lock();
        conclude();
    end

    // Watchdog: the tests need well under 2000 cycles
    initial begin
        #20000;
        fails++;
        conclude();
    end
endmodule
`default_nettype wire
